// >>> rtl/bfield_keystream_xor_regs.svh
// Purpose: Offsets, field sizes and segment lengths for the B-field key-stream combiner
// Assumes: Bit-serial operation, one key-stream bit and one payload bit per cycle
// Notes:   Definitions only
`ifndef BFIELD_KEYSTREAM_XOR_REGS_SVH
`define BFIELD_KEYSTREAM_XOR_REGS_SVH

// Start of the B-field window in the segment, default configurations
`define KS_OFFSET_DEFAULT   12'd40
// Start of the B-field window, configuration 4a
`define KS_OFFSET_CFG4A     12'd80
// Start of the B-field window, configuration 4b
`define KS_OFFSET_CFG4B     12'd120
// Spacing between subfield windows in multisubfield modes
`define KS_SUBFIELD_STRIDE  12'd80
// Data bits in one subfield
`define SUBFIELD_DATA_BITS  12'd64
// Segment length used at initialisation and synchronisation
`define KS_SYNC_SEGMENT_LEN 12'd1680
// Difference between segment length and q outside 4a and 4b
`define Q_MARGIN            12'd40

`endif

// >>> rtl/bfield_keystream_xor_pkg.sv
// Purpose: Types for the B-field key-stream combiner
// Assumes: Used together with bfield_keystream_xor_regs.svh
// Notes:   Configuration codes listed in modulation order
package bfield_keystream_xor_pkg;

  // Protection format of the B field
  typedef enum logic [1:0] {
    fmt_unprotected,
    fmt_multisubfield,
    fmt_constant_subfield,
    fmt_encoded_protected
  } bfield_format_e;

  // Modulation configuration
  typedef enum logic [3:0] {
    cfg_1a, cfg_1b, cfg_2, cfg_3, cfg_4a, cfg_4b, cfg_5, cfg_6
  } mod_config_e;

  // Burst set-up, held stable for the whole burst
  typedef struct packed {
    bfield_format_e format;
    mod_config_e    config_code;
    logic [11:0]    segment_length_max;
    logic [11:0]    q_tabulated;
    logic [3:0]     codec_ratio;
    logic [11:0]    subfield_len;
  } burst_cfg_s;

  // One payload bit with its check-sum mark
  typedef struct packed {
    logic data;
    logic is_checksum;
  } payload_bit_s;

endpackage

// >>> rtl/bfield_keystream_xor.sv
// What this block does
// - A field and segment generation unchanged; only B-field ciphering differs by format.
// - Constant-size-subfield mode splits B field into single-subfield-sized subfields.
// - Constant-size-subfield: check-sum bits pass plain, aligned key bits dropped.
// - Segment bits indexed zero to maximum minus one; maximum set per slot and modulation.
// - Encoded format: q is maximum minus 40, except tabulated q for 4a, 4b.
// - Encoded, default configs: key bits 40 onward XOR payload bits 0 to q*r-1.
// - Encoded, configuration 4a: key window starts at bit 80.
// - Encoded, configuration 4b: key window starts at bit 120.
// - Encoded: key bits beyond window discarded to segment end, never carried over.
// - Synchronisation uses one 1680-bit segment per burst.
// - Multisubfield: subfield x bit i XOR key bit 80x+i+40 by default.
//
// Purpose: Bit-serial XOR of a key-stream segment onto the B-field payload
// Assumes: Key stream arrives one bit per cycle, index 0 first, with valid/ready
// Notes:   A two-entry buffer sits in front of the output so a stalled receiver loses nothing
`timescale 1ns/100ps
`include "bfield_keystream_xor_regs.svh"

module bfield_keystream_xor (
  input  wire logic                                 clk,
  input  wire logic                                 reset,
  input  wire logic                                 burst_start,
  input  wire bfield_keystream_xor_pkg::burst_cfg_s cfg,
  input  wire logic                                 sync_mode,
  input  wire logic                                 ks_valid,
  output logic                                      ks_ready,
  input  wire logic                                 ks_bit,
  input  wire logic                                 pl_valid,
  output logic                                      pl_ready,
  input  wire bfield_keystream_xor_pkg::payload_bit_s pl_in,
  output logic                                      out_valid,
  input  wire logic                                 out_ready,
  output logic                                      out_bit,
  output logic                                      burst_busy
);
  import bfield_keystream_xor_pkg::*;

  typedef enum logic [1:0] {st_idle, st_run, st_flush} state_e;

  ////////////////////////////////////////////////////////////////////////////
  // Window geometry, derived from the burst set-up
  logic [11:0] win_start;
  logic [11:0] seg_len;
  logic [15:0] pay_len;
  logic [11:0] q_bits;

  always_comb begin
    case (cfg.config_code)
      cfg_4a:  win_start = `KS_OFFSET_CFG4A;
      cfg_4b:  win_start = `KS_OFFSET_CFG4B;
      default: win_start = `KS_OFFSET_DEFAULT;
    endcase
    if (cfg.config_code == cfg_4a || cfg.config_code == cfg_4b) begin
      q_bits = cfg.q_tabulated;
    end else begin
      q_bits = cfg.segment_length_max - `Q_MARGIN;
    end
    seg_len = sync_mode ? `KS_SYNC_SEGMENT_LEN : cfg.segment_length_max;
    pay_len = 16'(q_bits) * 16'(cfg.codec_ratio);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Segment walk
  state_e      state_q,   state_d;
  logic [11:0] ks_idx_q,  ks_idx_d;   // Index within the current segment
  logic [15:0] pl_idx_q,  pl_idx_d;   // Payload bits consumed
  logic [11:0] sub_pos_q, sub_pos_d;  // Position inside the subfield window
  logic [11:0] sub_base_q, sub_base_d;// Segment index where this subfield starts
  logic        buf_in_ready;
  logic        in_window;
  logic        ks_take;
  logic        pl_take;
  logic        emit;
  logic        emit_bit;
  logic [11:0] sub_len;
  logic [11:0] ks_last;

  always_comb begin
    // subfield size: constant-size uses 2-level single B field
    sub_len = (cfg.format == fmt_constant_subfield) ? cfg.subfield_len : `SUBFIELD_DATA_BITS;
    ks_last = seg_len - 12'h001;
    in_window = 1'b0;
    case (cfg.format)
      fmt_encoded_protected: in_window = (ks_idx_q >= win_start) && (pl_idx_q < pay_len);
      fmt_multisubfield,
      fmt_constant_subfield: in_window = (ks_idx_q >= sub_base_q) && (sub_pos_q < sub_len);
      // plain B field handled as unprotected
      fmt_unprotected:       in_window = (ks_idx_q >= win_start);
      default:               in_window = 1'b0;
    endcase
  end

  always_comb begin
    state_d    = state_q;
    ks_idx_d   = ks_idx_q;
    pl_idx_d   = pl_idx_q;
    sub_pos_d  = sub_pos_q;
    sub_base_d = sub_base_q;
    ks_take    = 1'b0;
    pl_take    = 1'b0;
    emit       = 1'b0;
    emit_bit   = 1'b0;
    case (state_q)
      st_idle: begin
        if (burst_start) begin
          state_d    = st_run;
          ks_idx_d   = 12'h000;
          pl_idx_d   = 16'h0000;
          sub_pos_d  = 12'h000;
          sub_base_d = win_start;
        end
      end
      st_run: begin
        if (!in_window) begin
          // Key bits outside any window are consumed and dropped
          ks_take = ks_valid;
        end else if (pl_valid && ks_valid && buf_in_ready) begin
          ks_take  = 1'b1;
          pl_take  = 1'b1;
          emit     = 1'b1;
          // check-sum bits pass plain, key bit dropped
          if (cfg.format == fmt_constant_subfield && pl_in.is_checksum) begin
            emit_bit = pl_in.data;
          end else begin
            emit_bit = pl_in.data ^ ks_bit;
          end
          pl_idx_d  = pl_idx_q + 16'h0001;
          sub_pos_d = sub_pos_q + 12'h001;
        end
        if (ks_take) begin
          ks_idx_d = ks_idx_q + 12'h001;
          // next subfield base advances by 80, or by the subfield length in constant-size mode
          if (in_window && sub_pos_d == sub_len && cfg.format != fmt_encoded_protected) begin
            sub_pos_d  = 12'h000;
            sub_base_d = sub_base_q + ((cfg.format == fmt_constant_subfield)
                                       ? sub_len : `KS_SUBFIELD_STRIDE);
          end
          // segment ends at its last index
          if (ks_idx_q == ks_last) begin
            state_d = st_flush;
          end
        end
      end
      st_flush: begin
        state_d = st_idle;
      end
      default: state_d = st_idle;
    endcase
  end

  // Segment walk registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q    <= st_idle;
      ks_idx_q   <= 12'h000;
      pl_idx_q   <= 16'h0000;
      sub_pos_q  <= 12'h000;
      sub_base_q <= 12'h000;
    end else begin
      state_q    <= state_d;
      ks_idx_q   <= ks_idx_d;
      pl_idx_q   <= pl_idx_d;
      sub_pos_q  <= sub_pos_d;
      sub_base_q <= sub_base_d;
    end
  end

  assign ks_ready   = ks_take;
  assign pl_ready   = pl_take;
  assign burst_busy = (state_q != st_idle);

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry output buffer; stall by the receiver stops payload intake
  logic [1:0] buf_data_q, buf_data_d;
  logic [1:0] buf_cnt_q,  buf_cnt_d;
  logic       rd_pop;

  always_comb begin
    buf_in_ready = (buf_cnt_q != 2'h2);
    rd_pop       = out_ready && (buf_cnt_q != 2'h0);
    buf_data_d   = buf_data_q;
    buf_cnt_d    = buf_cnt_q;
    if (rd_pop) begin
      buf_data_d = {1'b0, buf_data_q[1]};
    end
    if (emit) begin
      // Write lands behind whatever remains after the pop
      if ((rd_pop ? buf_cnt_q - 2'h1 : buf_cnt_q) == 2'h0) begin
        buf_data_d[0] = emit_bit;
      end else begin
        buf_data_d[1] = emit_bit;
      end
    end
    buf_cnt_d = buf_cnt_q + {1'b0, emit} - {1'b0, rd_pop};
  end

  // Buffer registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      buf_data_q <= 2'h0;
      buf_cnt_q  <= 2'h0;
    end else begin
      buf_data_q <= buf_data_d;
      buf_cnt_q  <= buf_cnt_d;
    end
  end

  assign out_valid = (buf_cnt_q != 2'h0);
  assign out_bit   = buf_data_q[0];

endmodule

// >>> tb/bfield_keystream_xor_sva.sv
// Purpose: Port checks of the B-field key-stream combiner
// Assumes: One clock, reset asynchronous and active high
// Notes:   Counters rebuild key and payload indices of a burst
`timescale 1ns/100ps
module bfield_keystream_xor_sva
  import bfield_keystream_xor_pkg::*;
(
  input wire logic         clk, reset, burst_start, sync_mode, ks_valid, ks_ready, ks_bit,
  input wire burst_cfg_s   cfg,
  input wire payload_bit_s pl_in,
  input wire logic         pl_ready, out_valid, out_ready, out_bit, burst_busy
);
  logic [11:0] ks_q, pl_q, st;
  logic        exp_q, go, enc;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////////
  // Window start by configuration; indices restart only on an accepted start
  assign st  = cfg.config_code == cfg_4a ? 12'h050 : cfg.config_code == cfg_4b ? 12'h078 : 12'h028;
  assign go  = burst_start && !burst_busy;
  assign enc = cfg.format == fmt_encoded_protected;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ks_q  <= '0;
      pl_q  <= '0;
      exp_q <= 1'b0;
    end else begin
      ks_q  <= go ? '0 : ks_q + 12'(ks_valid && ks_ready);
      pl_q  <= go ? '0 : pl_q + 12'(pl_ready);
      exp_q <= pl_in.data ^ (ks_bit & ~(cfg.format == fmt_constant_subfield & pl_in.is_checksum));
    end
  end
  property p_start; go |=> burst_busy; endproperty
  a_start: assert property (p_start) else $error("busy late");
  property p_win; pl_ready && enc |-> ks_q == pl_q + st; endproperty
  a_win: assert property (p_win) else $error("key offset wrong");
  property p_multi; pl_ready && cfg.format == fmt_multisubfield
    |-> ks_q == st + pl_q + {pl_q[11:6], 4'h0}; endproperty
  a_multi: assert property (p_multi) else $error("subfield offset wrong");
  property p_q; pl_ready && enc |-> pl_q < 12'((st != 12'h028 ? cfg.q_tabulated
    : cfg.segment_length_max - 12'h028) * cfg.codec_ratio); endproperty
  a_q: assert property (p_q) else $error("payload too long");
  property p_seg; ks_valid && ks_ready |-> ks_q < (sync_mode ? 12'h690 : cfg.segment_length_max);
  endproperty
  a_seg: assert property (p_seg) else $error("key beyond segment");
  property p_ans; pl_ready |=> out_valid; endproperty
  a_ans: assert property (p_ans) else $error("no output");
  property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_bit); endproperty
  a_hold: assert property (p_hold) else $error("output lost");
  property p_xor; pl_ready && !out_valid |=> out_bit == exp_q; endproperty
  a_xor: assert property (p_xor) else $error("cipher bit wrong");
  c_4b: cover property (pl_ready && cfg.config_code == cfg_4b);
  c_stall: cover property (out_valid && !out_ready);
  c_sync: cover property (burst_busy && sync_mode);
endmodule
bind bfield_keystream_xor bfield_keystream_xor_sva chk (.clk(clk), .reset(reset),
  .burst_start(burst_start), .sync_mode(sync_mode), .ks_valid(ks_valid), .ks_ready(ks_ready),
  .ks_bit(ks_bit), .cfg(cfg), .pl_in(pl_in), .pl_ready(pl_ready), .out_valid(out_valid),
  .out_ready(out_ready), .out_bit(out_bit), .burst_busy(burst_busy));

// >>> tb/bfield_keystream_xor_partner.sv
// Purpose: Key-stream source and output sink facing the combiner
// Assumes: Bench clock and reset
// Notes:   Slow mode gaps the key stream and stalls the sink
`timescale 1ns/100ps
module bfield_keystream_xor_partner (
  input wire logic    clk, reset, burst_start, burst_busy, slow, ks_ready,
  output logic        ks_valid, ks_bit, out_ready,
  output logic [11:0] ks_idx
);
  ////////////////////////////////////////////////////////////////////////////////
  // Key bits in index order
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ks_idx    <= '0;
      ks_valid  <= 1'b0;
      out_ready <= 1'b0;
    end else begin
      if (burst_start && !burst_busy) ks_idx <= '0;
      else if (ks_valid && ks_ready) ks_idx <= ks_idx + 12'h001;
      ks_valid  <= !ks_valid || !(slow && ks_ready);
      out_ready <= slow ? !out_ready : 1'b1;
    end
  end
  // Idle cycles show the inverse so an early sample is caught
  assign ks_bit = ks_valid ~^ (ks_idx[0] ^ ks_idx[2] ^ ks_idx[5]);
endmodule

// >>> tb/bfield_keystream_xor_tb.sv
// Purpose: Self-checking bench of the B-field key-stream combiner
// Assumes: Partner supplies key bits and drains output
// Notes:   Short segments except the sync burst
`timescale 1ns/100ps
module bfield_keystream_xor_tb;
  import bfield_keystream_xor_pkg::*;
  logic         clk = 1'b0, reset = 1'b1, burst_start = 1'b0, sync_mode = 1'b0;
  logic         pl_valid = 1'b0, slow = 1'b0;
  logic         ks_valid, ks_ready, ks_bit, pl_ready, out_valid, out_ready, out_bit, burst_busy;
  logic [11:0]  ks_idx;
  burst_cfg_s   cfg = '0;
  payload_bit_s pl_in = '0;
  int           n_mismatch = 0, tests_run = 0, k = 0, npl = 0;
  logic         got[$];
  ////////////////////////////////////////////////////////////////////////////////
  initial forever #20 clk = ~clk;
  bfield_keystream_xor DUT (.clk(clk), .reset(reset), .burst_start(burst_start), .cfg(cfg),
    .sync_mode(sync_mode), .ks_valid(ks_valid), .ks_ready(ks_ready), .ks_bit(ks_bit),
    .pl_valid(pl_valid), .pl_ready(pl_ready), .pl_in(pl_in), .out_valid(out_valid),
    .out_ready(out_ready), .out_bit(out_bit), .burst_busy(burst_busy));
  bfield_keystream_xor_partner far (.clk(clk), .reset(reset), .burst_start(burst_start),
    .burst_busy(burst_busy), .slow(slow), .ks_ready(ks_ready), .ks_valid(ks_valid),
    .ks_bit(ks_bit), .out_ready(out_ready), .ks_idx(ks_idx));
  // Payload bit k offered until taken; last two of every eight marked check-sum in constant-subfield bursts
  always @(negedge clk) begin
    pl_valid <= k < npl;
    pl_in    <= '{k[0] ^ k[2], cfg.format == fmt_constant_subfield && k[2:0] > 3'h5};
  end
  always @(posedge clk) begin
    if (pl_ready) k <= k + 1;
    if (out_valid && out_ready) got.push_back(out_bit);
  end
  function automatic logic ks_at(int i);
    return i[0] ^ i[2] ^ i[5];
  endfunction
  task automatic check(string what, logic [11:0] seen, logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // One burst; gap skips the unused key bits between 64-bit subfields
  task automatic burst(bfield_format_e f, mod_config_e c, logic [11:0] smax, logic [11:0] q,
                       logic [3:0] r, logic sy, int st, int gap, int n);
    logic e;
    @(negedge clk);
    cfg = '{f, c, smax, q, r, 12'h008};
    sync_mode = sy;
    slow = c[0];
    got.delete();
    k = 0;
    npl = n;
    burst_start = 1'b1;
    @(negedge clk);
    burst_start = 1'b0;
    for (int t = 0; t < 4000 && burst_busy !== 1'b0; t++) @(negedge clk);
    // A burst that never ends counts as a mismatch here
    check("burst_end", {11'h000, burst_busy}, 12'h000);
    repeat (6) @(negedge clk);
    check("out_count", 12'(got.size()), 12'(n));
    check("key_count", ks_idx, sy ? 12'h690 : smax);
    foreach (got[i]) begin
      e = ks_at(st + i + gap * (i / 64)) & !(f == fmt_constant_subfield && i % 8 > 5);
      check("out_bit", {11'h000, got[i]}, {11'h000, e ^ i[0] ^ i[2]});
    end
  endtask
  task automatic t_encoded_configs();
    for (int j = 0; j < 8; j++) begin
      if (j == 4) begin
        burst(fmt_encoded_protected, cfg_4a, 12'h0a0, 12'h008, 4'h2, 1'b0, 80, 0, 16);
      end else if (j == 5) begin
        burst(fmt_encoded_protected, cfg_4b, 12'h0a0, 12'h008, 4'h2, 1'b0, 120, 0, 16);
      end else begin
        burst(fmt_encoded_protected, mod_config_e'(j), 12'h0a0, 12'h000, 4'h1, 1'b0,
              40, 0, 120);
      end
    end
  endtask
  task automatic t_constant_subfield();
    burst(fmt_constant_subfield, cfg_2, 12'h038, 12'h000, 4'h1, 1'b0, 40, 0, 16);
  endtask
  // Unprotected B field ciphered from the window start to segment end
  task automatic t_unprotected();
    burst(fmt_unprotected, cfg_2, 12'h038, 12'h000, 4'h1, 1'b0, 40, 0, 16);
  endtask
  task automatic t_multisubfield();
    burst(fmt_multisubfield, cfg_1b, 12'h0c8, 12'h000, 4'h1, 1'b0, 40, 16, 128);
  endtask
  task automatic t_sync_segment();
    burst(fmt_encoded_protected, cfg_3, 12'h038, 12'h000, 4'h1, 1'b1, 40, 0, 16);
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk);
    reset = 1'b0;
    t_encoded_configs();
    t_constant_subfield();
    t_unprotected();
    t_multisubfield();
    t_sync_segment();
    summarize();
  end
  // Watchdog, more than three times the expected run
  initial begin
    #800000;
    n_mismatch++;
    summarize();
  end
endmodule
